// >>> pbmc_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 250 MHz system clock, 16-bit management registers
// Notes:   definitions only
`ifndef PBMC_REGS_SVH
`define PBMC_REGS_SVH

`define PBMC_ADDR_W       5
`define PBMC_CTRL_OFF     5'h00
`define PBMC_EVT_OFF      5'h1E

`define PBMC_B_RESET      15
`define PBMC_B_LOOP       14
`define PBMC_B_SPD_LSB    13
`define PBMC_B_AN_EN      12
`define PBMC_B_PDN        11
`define PBMC_B_ISO        10
`define PBMC_B_RESTART    9
`define PBMC_B_DUPLEX     8
`define PBMC_B_COLT       7
`define PBMC_B_SPD_MSB    6

`define PBMC_CTRL_RST     16'h0040
`define PBMC_CTRL_WMASK   16'h7FC0

`define PBMC_EVT_B_LINK   0
`define PBMC_EVT_B_FAULT  1
`define PBMC_EVT_B_RXERR  2
// arbitrary fixed pattern in the permanent read-only field
`define PBMC_EVT_FIXED    4'h5

`define PBMC_CLK_NS       4
`define PBMC_SRST_NS      1000
`define PBMC_SRST_CYC     ((`PBMC_SRST_NS + `PBMC_CLK_NS - 1) / `PBMC_CLK_NS)
// bit times at 1000 Mbit/s, one bit per ns: the tightest case
`define PBMC_COL_ON_NS    512
`define PBMC_COL_OFF_NS   4
`define PBMC_COL_ON_CYC   (`PBMC_COL_ON_NS / `PBMC_CLK_NS)
`define PBMC_COL_OFF_CYC  (`PBMC_COL_OFF_NS / `PBMC_CLK_NS)

`endif

// >>> pbmc_pkg.sv
// Purpose: shared types of the basic mode control block
// Assumes: nothing
// Notes:   constants live in pbmc_regs.svh
package pbmc_pkg;

  typedef enum logic [2:0]
  {
    pbmc_st_load = 3'h1,
    pbmc_st_run  = 3'h2,
    pbmc_st_srst = 3'h4
  } pbmc_state_t;

  typedef enum logic [1:0]
  {
    pbmc_spd_10   = 2'h0,
    pbmc_spd_100  = 2'h1,
    pbmc_spd_1000 = 2'h2,
    pbmc_spd_rsvd = 2'h3
  } pbmc_speed_t;

  typedef enum logic [1:0]
  {
    pbmc_flag_lh  = 2'h0,
    pbmc_flag_ll  = 2'h1,
    pbmc_flag_cor = 2'h2
  } pbmc_flag_t;

endpackage

// >>> pbmc_flag_cell.sv
// Purpose: one sticky status flag, latched high, latched low or clear on read
// Assumes: event_i and rd_clr_i synchronous to clk_sys_i
// Notes:   an event in the read cycle wins over the clear
`timescale 1ns/1ns
`default_nettype none
module pbmc_flag_cell
  import pbmc_pkg::*;
#(
  parameter pbmc_flag_t MODE = pbmc_flag_lh
)(
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic event_i,
  input  wire logic rd_clr_i,
  output var  logic flag_o
);

  localparam logic ACT = (MODE == pbmc_flag_ll) ? 1'b0 : 1'b1;

  logic flag_r;
  logic flag_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    if (event_i)
      flag_nxt = ACT;
    else if (rd_clr_i)
      flag_nxt = ~ACT;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag_o = flag_r;

  AST_FLAG_LATCH: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    event_i |=> flag_o == ACT)
    else $error("flag did not latch its event");

  AST_FLAG_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_clr_i && !event_i) |=> flag_o == ~ACT)
    else $error("flag not cleared by read");

endmodule
`default_nettype wire

// >>> pbmc_ctrl.sv
// Purpose: basic mode control register and its effect on the MAC path
// Assumes: management strobes and all pins synchronous to clk_sys_i
// Notes:   reads answer one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_regs.svh"
module pbmc_ctrl
  import pbmc_pkg::*;
#(
  parameter int unsigned SRST_CYCLES = `PBMC_SRST_CYC,
  parameter int unsigned DW          = 8
)(
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  input  wire logic                    mgmt_wr_i,
  input  wire logic                    mgmt_rd_i,
  input  wire logic [`PBMC_ADDR_W-1:0] mgmt_addr_i,
  input  wire logic [15:0]             mgmt_wdata_i,
  output var  logic [15:0]             mgmt_rdata_o,
  output var  logic                    mgmt_rvalid_o,
  input  wire logic                    strap_an_en_i,
  input  wire logic                    strap_duplex_i,
  input  wire logic                    power_down_pin_n_i,
  input  wire logic                    an_started_i,
  input  wire logic [1:0]              an_speed_i,
  input  wire logic                    an_duplex_i,
  input  wire logic                    link_ok_i,
  input  wire logic                    remote_fault_i,
  input  wire logic                    rx_err_i,
  input  wire logic [DW-1:0]           mac_txd_i,
  input  wire logic                    mac_tx_en_i,
  input  wire logic [DW-1:0]           line_rxd_i,
  input  wire logic                    line_rx_dv_i,
  input  wire logic                    line_col_i,
  output var  logic [DW-1:0]           mac_rxd_o,
  output var  logic                    mac_rx_dv_o,
  output var  logic                    mac_col_o,
  output var  logic                    mac_oe_o,
  output var  logic [DW-1:0]           line_txd_o,
  output var  logic                    line_tx_en_o,
  output var  logic                    an_restart_o,
  output var  logic                    an_enable_o,
  output var  logic [1:0]              speed_o,
  output var  logic                    full_duplex_o,
  output var  logic                    power_down_o,
  output var  logic                    soft_reset_o
);

  localparam int CW        = $clog2(SRST_CYCLES + 1);
  localparam int SRST_MAX  = SRST_CYCLES + 2;
  localparam int COL_ON    = `PBMC_COL_ON_CYC;
  localparam int COL_OFF   = `PBMC_COL_OFF_CYC;

  function automatic logic hit(input logic [`PBMC_ADDR_W-1:0] a,
                               input logic [`PBMC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // soft reset sequencer and control bits
  pbmc_state_t     st_r;
  pbmc_state_t     st_nxt;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  logic [15:0]     ctrl_r;
  logic [15:0]     ctrl_nxt;
  logic            ctrl_wr;
  logic            srst_busy;
  logic            pdn_eff;
  logic            gate;

  assign ctrl_wr   = mgmt_wr_i && hit(mgmt_addr_i, `PBMC_CTRL_OFF);
  assign srst_busy = (st_r != pbmc_st_run);
  assign pdn_eff   = ctrl_r[`PBMC_B_PDN] | ~power_down_pin_n_i;
  assign gate      = pdn_eff | ctrl_r[`PBMC_B_ISO];

  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    ctrl_nxt = ctrl_r;
    unique case (st_r)
      pbmc_st_load:
      begin
        ctrl_nxt                 = `PBMC_CTRL_RST;
        ctrl_nxt[`PBMC_B_AN_EN]  = strap_an_en_i;
        ctrl_nxt[`PBMC_B_DUPLEX] = strap_duplex_i;
        st_nxt                   = pbmc_st_run;
      end
      pbmc_st_run:
      begin
        ctrl_nxt[`PBMC_B_RESTART] = ctrl_r[`PBMC_B_RESTART]
                                    & ~an_started_i;
        if (ctrl_wr)
        begin
          // reserved bits and bit 15 never stored
          ctrl_nxt = (mgmt_wdata_i & `PBMC_CTRL_WMASK);
          // a written zero cannot cancel a pending restart
          ctrl_nxt[`PBMC_B_RESTART] = (ctrl_r[`PBMC_B_RESTART]
                                       & ~an_started_i)
                                      | (mgmt_wdata_i[`PBMC_B_RESTART]
                                         & mgmt_wdata_i[`PBMC_B_AN_EN]);
          if (mgmt_wdata_i[`PBMC_B_RESET])
          begin
            st_nxt  = pbmc_st_srst;
            cnt_nxt = CW'(SRST_CYCLES - 1);
          end
        end
      end
      pbmc_st_srst:
      begin
        if (cnt_r == '0)
          st_nxt = pbmc_st_load;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_r   <= pbmc_st_load;
      cnt_r  <= '0;
      ctrl_r <= `PBMC_CTRL_RST;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign an_restart_o = ctrl_r[`PBMC_B_RESTART];
  assign an_enable_o  = ctrl_r[`PBMC_B_AN_EN];
  assign power_down_o = pdn_eff;
  assign soft_reset_o = srst_busy;
  assign mac_oe_o     = ~ctrl_r[`PBMC_B_ISO];

  // event flags
  logic evt_rd;
  logic [2:0] evt_flag;

  assign evt_rd = mgmt_rd_i && hit(mgmt_addr_i, `PBMC_EVT_OFF);

  pbmc_flag_cell #(.MODE(pbmc_flag_ll)) u_link
  (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .event_i   (~link_ok_i),
    .rd_clr_i  (evt_rd),
    .flag_o    (evt_flag[`PBMC_EVT_B_LINK])
  );

  pbmc_flag_cell #(.MODE(pbmc_flag_lh)) u_fault
  (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .event_i   (remote_fault_i),
    .rd_clr_i  (evt_rd),
    .flag_o    (evt_flag[`PBMC_EVT_B_FAULT])
  );

  pbmc_flag_cell #(.MODE(pbmc_flag_cor)) u_rxerr
  (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .event_i   (rx_err_i),
    .rd_clr_i  (evt_rd),
    .flag_o    (evt_flag[`PBMC_EVT_B_RXERR])
  );

  // management read port
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  always_comb
  begin
    rdata_nxt  = 16'h0000;
    rvalid_nxt = mgmt_rd_i;
    if (mgmt_rd_i && hit(mgmt_addr_i, `PBMC_CTRL_OFF))
    begin
      rdata_nxt                  = ctrl_r & `PBMC_CTRL_WMASK;
      rdata_nxt[`PBMC_B_RESET]   = srst_busy;
      rdata_nxt[`PBMC_B_PDN]     = pdn_eff;
    end
    else if (evt_rd)
    begin
      rdata_nxt[15:12] = `PBMC_EVT_FIXED;
      rdata_nxt[2:0]   = evt_flag;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign mgmt_rdata_o  = rdata_r;
  assign mgmt_rvalid_o = rvalid_r;

  // MAC data path, speed and duplex
  logic [DW-1:0] rxd_nxt;
  logic          rxdv_nxt;
  logic          col_nxt;
  logic [DW-1:0] txd_nxt;
  logic          txen_nxt;
  logic [1:0]    spd_nxt;
  logic          dup_nxt;
  logic [DW-1:0] rxd_r;
  logic          rxdv_r;
  logic          col_r;
  logic [DW-1:0] txd_r;
  logic          txen_r;
  logic [1:0]    spd_r;
  logic          dup_r;

  always_comb
  begin
    rxd_nxt  = line_rxd_i;
    rxdv_nxt = line_rx_dv_i;
    txd_nxt  = mac_txd_i;
    txen_nxt = mac_tx_en_i;
    col_nxt  = ctrl_r[`PBMC_B_COLT] ? mac_tx_en_i : line_col_i;
    if (ctrl_r[`PBMC_B_LOOP])
    begin
      rxd_nxt  = mac_txd_i;
      rxdv_nxt = mac_tx_en_i;
      txen_nxt = 1'b0;
    end
    if (gate)
    begin
      rxd_nxt  = '0;
      rxdv_nxt = 1'b0;
      col_nxt  = 1'b0;
      txd_nxt  = '0;
      txen_nxt = 1'b0;
    end
    if (ctrl_r[`PBMC_B_AN_EN])
    begin
      spd_nxt = an_speed_i;
      dup_nxt = an_duplex_i;
    end
    else
    begin
      spd_nxt = {ctrl_r[`PBMC_B_SPD_MSB], ctrl_r[`PBMC_B_SPD_LSB]};
      dup_nxt = ctrl_r[`PBMC_B_DUPLEX];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rxd_r  <= '0;
      rxdv_r <= 1'b0;
      col_r  <= 1'b0;
      txd_r  <= '0;
      txen_r <= 1'b0;
      spd_r  <= pbmc_spd_1000;
      dup_r  <= 1'b0;
    end
    else
    begin
      rxd_r  <= rxd_nxt;
      rxdv_r <= rxdv_nxt;
      col_r  <= col_nxt;
      txd_r  <= txd_nxt;
      txen_r <= txen_nxt;
      spd_r  <= spd_nxt;
      dup_r  <= dup_nxt;
    end
  end

  assign mac_rxd_o     = rxd_r;
  assign mac_rx_dv_o   = rxdv_r;
  assign mac_col_o     = col_r;
  assign line_txd_o    = txd_r;
  assign line_tx_en_o  = txen_r;
  assign speed_o       = spd_r;
  assign full_duplex_o = dup_r;

  logic rd_ctrl_r;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rd_ctrl_r <= 1'b0;
    else
      rd_ctrl_r <= mgmt_rd_i && hit(mgmt_addr_i, `PBMC_CTRL_OFF);
  end

  AST_SRST_DONE: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(srst_busy) |-> ##[1:SRST_MAX] !srst_busy)
    else $error("soft reset did not complete in time");

  AST_SRST_DEFAULTS: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(srst_busy) |-> (ctrl_r & 16'h6EC0) == `PBMC_CTRL_RST)
    else $error("control bits not back at defaults");

  AST_STRAP_LOAD: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    st_r == pbmc_st_load |=> ctrl_r[`PBMC_B_AN_EN] == $past(strap_an_en_i)
      && ctrl_r[`PBMC_B_DUPLEX] == $past(strap_duplex_i))
    else $error("strap value not loaded");

  AST_LOOPBACK: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_r[`PBMC_B_LOOP] && !gate) |=> mac_rxd_o == $past(mac_txd_i)
      && mac_rx_dv_o == $past(mac_tx_en_i))
    else $error("loopback data mismatch");

  AST_SPEED_MANUAL: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !ctrl_r[`PBMC_B_AN_EN] |=> speed_o == $past({ctrl_r[`PBMC_B_SPD_MSB],
                                              ctrl_r[`PBMC_B_SPD_LSB]}))
    else $error("manual speed not applied");

  AST_SPEED_AN: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ctrl_r[`PBMC_B_AN_EN] |=> speed_o == $past(an_speed_i)
      && full_duplex_o == $past(an_duplex_i))
    else $error("negotiated speed not applied");

  AST_PDN_PIN: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!power_down_pin_n_i && mgmt_rd_i && hit(mgmt_addr_i, `PBMC_CTRL_OFF))
      |=> mgmt_rdata_o[`PBMC_B_PDN] && power_down_o)
    else $error("power-down pin not reflected");

  AST_ISOLATE: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    ctrl_r[`PBMC_B_ISO] |=> !mac_rx_dv_o && !mac_col_o && !line_tx_en_o)
    else $error("isolated port still drives");

  AST_COL_ON: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_r[`PBMC_B_COLT] && !gate && mac_tx_en_i)
      |-> ##[1:COL_ON] mac_col_o)
    else $error("collision test did not raise COL");

  AST_COL_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_r[`PBMC_B_COLT] && !mac_tx_en_i) |-> ##[1:COL_OFF] !mac_col_o)
    else $error("collision test did not drop COL");

  AST_RESTART_IGNORED: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_wr && !srst_busy && !mgmt_wdata_i[`PBMC_B_AN_EN]
      && !ctrl_r[`PBMC_B_RESTART]) |=> !an_restart_o)
    else $error("restart taken with negotiation off");

  AST_RESTART_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (an_restart_o && !an_started_i && !srst_busy) |=> an_restart_o)
    else $error("pending restart dropped early");

  AST_RSVD_ZERO: assert property (
    @(posedge clk_sys_i) disable iff (!rstn_i)
    rd_ctrl_r |-> mgmt_rdata_o[5:0] == 6'h00 && mgmt_rvalid_o)
    else $error("reserved control bits not zero");

endmodule
`default_nettype wire

// >>> pbmc_an_partner.sv
// Purpose: negotiation engine stand-in answering the restart request
// Assumes: restart_i is a level from the control block
// Notes:   reports one start pulse DELAY + 1 cycles after a request
`timescale 1ns/1ns
`default_nettype none
module pbmc_an_partner
#(
  parameter int unsigned DELAY = 8
)(
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic restart_i,
  output var  logic started_o
);
  int unsigned cnt_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r     <= 0;
      started_o <= 1'b0;
    end
    else
    begin
      // one start per request, late enough to see the request stand
      started_o <= restart_i && (cnt_r == DELAY) && !started_o;
      if (!restart_i)
        cnt_r <= 0;
      else if (cnt_r < DELAY)
        cnt_r <= cnt_r + 1;
    end
  end
endmodule
`default_nettype wire

// >>> phy_basic_mode_control_test.sv
// Purpose: self-checking bench of the basic mode control register
// Assumes: inputs change on the falling clock edge
// Notes:   soft reset shortened to four cycles
`timescale 1ns/1ns
`default_nettype none
`include "pbmc_regs.svh"
module phy_basic_mode_control_test;
  import pbmc_pkg::*;
  localparam int unsigned DW = 8;
  localparam int unsigned SRST = 4;
  localparam logic [15:0] MODES [4] = '{16'h0140, 16'h4140, 16'h0540,
                                        16'h0940};
  logic          clk_sys_i, rstn_i, wr, rd, rvalid, s_an, s_dup, pin_n;
  logic [4:0]    addr;
  logic [15:0]   wdata, rdata, m_ctrl, v, w;
  logic          an_st, link, fault, rxerr, an_dup, fdup, pdn, srst;
  logic          an_rst, an_en, tx_en, lrx_dv, lcol, mrx_dv, mcol, moe;
  logic          ltx_en;
  logic [1:0]    an_spd, spd;
  logic [DW-1:0] txd, lrxd, mrxd, ltxd;
  int            n_errors, check_count, n;

  pbmc_ctrl #(.SRST_CYCLES(SRST), .DW(DW)) i_dut
  (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mgmt_wr_i(wr),
    .mgmt_rd_i(rd), .mgmt_addr_i(addr), .mgmt_wdata_i(wdata),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .strap_an_en_i(s_an),
    .strap_duplex_i(s_dup), .power_down_pin_n_i(pin_n),
    .an_started_i(an_st), .an_speed_i(an_spd), .an_duplex_i(an_dup),
    .link_ok_i(link), .remote_fault_i(fault), .rx_err_i(rxerr),
    .mac_txd_i(txd), .mac_tx_en_i(tx_en), .line_rxd_i(lrxd),
    .line_rx_dv_i(lrx_dv), .line_col_i(lcol), .mac_rxd_o(mrxd),
    .mac_rx_dv_o(mrx_dv), .mac_col_o(mcol), .mac_oe_o(moe),
    .line_txd_o(ltxd), .line_tx_en_o(ltx_en), .an_restart_o(an_rst),
    .an_enable_o(an_en), .speed_o(spd), .full_duplex_o(fdup),
    .power_down_o(pdn), .soft_reset_o(srst)
  );

  pbmc_an_partner #(.DELAY(8)) i_partner
  (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .restart_i(an_rst),
    .started_o(an_st)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk_rd(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_out(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [15:0] rexp();
    return {1'b0, m_ctrl[14:12], m_ctrl[11] | ~pin_n, m_ctrl[10:6], 6'h00};
  endfunction

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    addr = a;
    rd   = 1'b1;
    @(negedge clk_sys_i);
    rd = 1'b0;
    chk_out("rvalid", 16'h0001, {15'h0000, rvalid});
    d = rdata;
    @(negedge clk_sys_i);
  endtask

  // 0 collision, 1 restart request, else soft reset
  function automatic logic pick(input int sel);
    case (sel)
      0:       pick = mcol;
      1:       pick = an_rst;
      default: pick = srst;
    endcase
  endfunction

  // bounded wait for a design output to reach a level
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    n = 0;
    while (pick(sel) !== lvl && n < lim)
    begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask

  task automatic dp_chk();
    logic lb;
    logic off;
    lb  = m_ctrl[14];
    off = m_ctrl[11] | m_ctrl[10];
    chk_out("mac_rxd", off ? 16'h0 : {8'h00, lb ? txd : lrxd},
            {8'h00, mrxd});
    chk_out("mac_rx_dv", {15'h0, ~off & (lb ? tx_en : lrx_dv)},
            {15'h0, mrx_dv});
    chk_out("line_tx_en", {15'h0, ~off & ~lb & tx_en},
            {15'h0, ltx_en});
    chk_out("mac_oe", {15'h0, ~m_ctrl[10]}, {15'h0, moe});
    if (!lb)
    begin
      chk_out("line_txd", off ? 16'h0 : {8'h00, txd}, {8'h00, ltxd});
      chk_out("mac_col", {15'h0, ~off & lcol}, {15'h0, mcol});
    end
  endtask

  initial
  begin
    rstn_i = 1'b0;
    {wr, rd, addr, wdata, pin_n, link, fault, rxerr} = 27'h0;
    {an_spd, an_dup, txd, lrxd, tx_en, lrx_dv, lcol} = 22'h0;
    pin_n       = 1'b1;
    link        = 1'b1;
    n_errors    = 0;
    check_count = 0;
    void'($urandom(83534));
    s_an  = 1'($urandom);
    s_dup = 1'($urandom);
    repeat (20) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    m_ctrl = `PBMC_CTRL_RST | {3'h0, s_an, 3'h0, s_dup, 8'h00};
    rd_reg(`PBMC_CTRL_OFF, v);
    chk_rd("ctrl_reset", rexp(), v);
    $display("test reset_values done");

    for (int i = 0; i < 8; i++)
    begin
      w      = 16'($urandom) & 16'h6FFF;
      pin_n  = 1'($urandom);
      m_ctrl = w & 16'h6DC0;
      wr_reg(`PBMC_CTRL_OFF, w);
      chk_out("power_down", {15'h0, w[11] | ~pin_n}, {15'h0, pdn});
      chk_out("speed", {14'h0, w[6], w[13]}, {14'h0, spd});
      chk_out("duplex", {15'h0, w[8]}, {15'h0, fdup});
      rd_reg(`PBMC_CTRL_OFF, v);
      chk_rd("ctrl_rw", rexp(), v);
    end
    $display("test random_writes done");

    pin_n = 1'b1;
    // the MAC side here tolerates any idle gap after loopback
    for (int i = 0; i < 4; i++)
    begin
      m_ctrl = MODES[i];
      wr_reg(`PBMC_CTRL_OFF, MODES[i]);
      repeat (4)
      begin
        {txd, lrxd}           = 16'($urandom);
        {tx_en, lrx_dv, lcol} = 3'($urandom);
        @(negedge clk_sys_i);
        dp_chk();
      end
    end
    $display("test data_path done");

    m_ctrl = 16'h01C0;
    wr_reg(`PBMC_CTRL_OFF, m_ctrl);
    lcol  = 1'b0;
    tx_en = 1'b1;
    wait_for(0, 1'b1, `PBMC_COL_ON_CYC);
    chk_out("col_on", 16'h0001, {15'h0, mcol});
    tx_en = 1'b0;
    wait_for(0, 1'b0, `PBMC_COL_OFF_CYC);
    chk_out("col_off", 16'h0000, {15'h0, mcol});
    $display("test collision done");

    an_spd = 2'($urandom_range(2));
    an_dup = 1'($urandom);
    wr_reg(`PBMC_CTRL_OFF, 16'h0200);
    chk_out("restart_off", 16'h0000, {15'h0, an_rst});
    wr_reg(`PBMC_CTRL_OFF, 16'h1240);
    chk_out("restart_on", 16'h0001, {15'h0, an_rst});
    wr_reg(`PBMC_CTRL_OFF, 16'h3140);
    m_ctrl = 16'h3340;
    rd_reg(`PBMC_CTRL_OFF, v);
    chk_rd("restart_kept", rexp(), v);
    chk_out("an_speed", {14'h0, an_spd}, {14'h0, spd});
    chk_out("an_duplex", {15'h0, an_dup}, {15'h0, fdup});
    chk_out("an_enable", 16'h0001, {15'h0, an_en});
    wait_for(1, 1'b0, 20);
    m_ctrl = 16'h3140;
    rd_reg(`PBMC_CTRL_OFF, v);
    chk_rd("restart_done", rexp(), v);
    $display("test restart done");

    s_an  = ~s_an;
    s_dup = ~s_dup;
    wr_reg(`PBMC_CTRL_OFF, 16'hC940);
    chk_out("soft_reset", 16'h0001, {15'h0, srst});
    rd_reg(`PBMC_CTRL_OFF, v);
    chk_rd("reset_busy", 16'h8000, v & 16'h8000);
    wait_for(2, 1'b0, SRST + 4);
    m_ctrl = `PBMC_CTRL_RST | {3'h0, s_an, 3'h0, s_dup, 8'h00};
    rd_reg(`PBMC_CTRL_OFF, v);
    chk_rd("ctrl_restrap", rexp(), v);
    $display("test soft_reset done");

    rd_reg(`PBMC_EVT_OFF, v);
    rd_reg(`PBMC_EVT_OFF, v);
    chk_rd("evt_idle", 16'h5001, v);
    wr_reg(`PBMC_EVT_OFF, 16'hFFFF);
    {link, fault, rxerr} = 3'b011;
    @(negedge clk_sys_i);
    {link, fault, rxerr} = 3'b100;
    repeat (2) @(negedge clk_sys_i);
    rd_reg(`PBMC_EVT_OFF, v);
    chk_rd("evt_hit", 16'h5006, v);
    rd_reg(`PBMC_EVT_OFF, v);
    chk_rd("evt_clear", 16'h5001, v);
    rd_reg(5'h05, v);
    chk_rd("unmapped", 16'h0000, v);
    $display("test event_flags done");
    give_verdict();
  end

  initial
  begin
    #40000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
